// ===== hw/fmp_pkg.sv
// shared constants and carriers for the field memory pointer control
package fmp_pkg;

    // memory organisation
    localparam int LINES      = 306;
    localparam int BLOCKS     = 16;
    localparam int BLOCK_BITS = 60;
    localparam int LINE_W     = 9;
    localparam int BLOCK_W    = 4;
    localparam int BIT_W      = 6;

    localparam logic [8:0] LAST_LINE  = 9'h131;
    localparam logic [3:0] LAST_BLOCK = 4'hF;
    localparam logic [5:0] LAST_BIT   = 6'h3B;

    // reset values
    localparam logic [8:0] LINE_RST  = 9'h000;
    localparam logic [3:0] BLOCK_RST = 4'h0;
    localparam logic [5:0] BIT_RST   = 6'h00;

    // read lag and transfer sync pulse counts, in port clock cycles
    localparam int         READ_LAG      = 64;
    localparam logic [6:0] READ_LAG_LOAD = 7'(READ_LAG - 1);
    localparam logic [2:0] SYNC_PULSES_W = 3'h5;

    typedef struct packed {
        logic line_restart;
        logic block_restart;
        logic line_inc;
    } fmp_strobe_s;

    typedef struct packed {
        logic [8:0] line;
        logic [3:0] block;
    } fmp_addr_s;

    // line sum modulo the line count
    function automatic logic [8:0] fmp_line_add(input logic [8:0] v,
                                                input logic [8:0] n);
        logic [9:0] s;
        s = {1'b0, v} + {1'b0, n};
        if (s >= 10'(LINES)) begin
            s = s - 10'(LINES);
        end
        return s[8:0];
    endfunction

    // saturating increment counter step
    function automatic logic [8:0] fmp_inc_sat(input logic [8:0] n);
        return (n == LAST_LINE) ? n : n + 9'h001;
    endfunction

endpackage

// ===== hw/fmp_tsync.sv
// transfer sync pulse generator and receiver for the write port
`timescale 1ns/1ps
module fmp_tsync
    import fmp_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // control
    input  wire logic tick_in,
    input  wire logic master_in,
    input  wire logic fire_in,
    // pin
    input  wire logic sync_in,
    output logic      sync_out,
    output logic      sync_oe_out,
    output logic      seen_out
);

    logic [2:0] cnt_r;

    // pulse train length after each block transfer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= 3'h0;
        end else if (tick_in && master_in) begin
            if (fire_in) begin
                cnt_r <= SYNC_PULSES_W - 3'h1;
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end
        end
    end

    // master drives the pin with the write clock
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_out    <= 1'b0;
            sync_oe_out <= 1'b0;
        end else begin
            sync_oe_out <= master_in;
            if (!master_in) begin
                sync_out <= 1'b0;
            end else if (tick_in) begin
                sync_out <= fire_in || cnt_r != 3'h0;
            end
        end
    end

    // slave catches the master's pulse
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seen_out <= 1'b0;
        end else if (tick_in) begin
            seen_out <= !master_in && sync_in;
        end
    end

endmodule // fmp_tsync

// ===== hw/fmp_rd_port.sv
// read port pointer sequencer with fixed output lag
`timescale 1ns/1ps
module fmp_rd_port
    import fmp_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // port controls
    input  wire logic        tick_in,
    input  wire fmp_strobe_s strobe_in,
    input  wire logic        recursive_in,
    // array side
    input  wire logic [59:0] word_in,
    output fmp_addr_s        addr_out,
    // serial output
    output logic             bit_out,
    output logic             active_out
);

    logic [5:0] bit_r;
    logic [6:0] lag_r;
    logic       lr_pend_r;
    logic [8:0] inc_r;
    logic       restart;
    logic       inc_ok;
    logic       blk_end;
    logic [8:0] n_eff;

    always_comb begin
        restart = recursive_in ? strobe_in.line_restart
                               : strobe_in.block_restart;
        inc_ok  = strobe_in.line_inc && !strobe_in.line_restart;
        blk_end = active_out && lag_r == 7'h00 && bit_r == LAST_BIT;
        n_eff   = inc_ok ? fmp_inc_sat(inc_r) : inc_r;
    end

    // line and block pointer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_out   <= '0;
            active_out <= 1'b0;
            lag_r      <= 7'h00;
        end else if (tick_in) begin
            if (restart) begin
                active_out     <= 1'b1;
                lag_r          <= READ_LAG_LOAD;
                addr_out.block <= BLOCK_RST;
                if (recursive_in) begin
                    addr_out.line <= LINE_RST;
                end else if (strobe_in.line_restart || lr_pend_r) begin
                    addr_out.line <= fmp_line_add(LINE_RST, n_eff);
                end else begin
                    addr_out.line <= fmp_line_add(addr_out.line, n_eff);
                end
            end else if (lag_r != 7'h00) begin
                lag_r <= lag_r - 7'h01;
            end else if (blk_end) begin
                if (recursive_in) begin
                    addr_out.block <= addr_out.block + 4'h1;
                    if (addr_out.block == LAST_BLOCK) begin
                        addr_out.line <= (addr_out.line == LAST_LINE) ?
                            LINE_RST : addr_out.line + 9'h001;
                    end
                end else begin
                    if (lr_pend_r) begin
                        addr_out.line <= fmp_line_add(LINE_RST, inc_r);
                    end
                    if (addr_out.block == LAST_BLOCK && !lr_pend_r) begin
                        active_out <= 1'b0;
                    end else begin
                        addr_out.block <= addr_out.block + 4'h1;
                    end
                end
            end
        end
    end

    // pending line reset and increment count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lr_pend_r <= 1'b0;
            inc_r     <= 9'h000;
        end else if (tick_in) begin
            if (restart || (blk_end && lr_pend_r)) begin
                lr_pend_r <= 1'b0;
                inc_r     <= 9'h000;
            end else if (!recursive_in && strobe_in.line_restart) begin
                lr_pend_r <= 1'b1;
                inc_r     <= 9'h000;
            end else if (!recursive_in && inc_ok) begin
                inc_r <= fmp_inc_sat(inc_r);
            end
        end
    end

    // bit position and serial output; holds during the lag
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_r   <= BIT_RST;
            bit_out <= 1'b0;
        end else if (tick_in) begin
            if (restart) begin
                bit_r <= BIT_RST;
            end else if (active_out && lag_r == 7'h00) begin
                bit_out <= word_in[bit_r];
                bit_r   <= (bit_r == LAST_BIT) ? BIT_RST : bit_r + 6'h01;
            end
        end
    end

endmodule // fmp_rd_port

// ===== hw/fmp_field_ctrl.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module fmp_field_ctrl
    import fmp_pkg::*;
#(
    parameter int RD_PORTS = 2
) (
    // clock and reset
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    // mode pins
    input  wire logic            recursive_select_in,
    input  wire logic            preset_select_in,
    input  wire logic            sync_role_select_in,
    // write port
    input  wire logic            write_port_clock_in,
    input  wire fmp_strobe_s     wr_strobe_in,
    input  wire logic            wr_gate_n_in,
    input  wire logic [3:0]      wr_preset_block_in,
    input  wire logic            wr_data_in,
    output logic                 wr_commit_out,
    output fmp_addr_s            wr_addr_out,
    output logic [59:0]          wr_word_out,
    // transfer sync pin
    input  wire logic            transfer_sync_in,
    output logic                 transfer_sync_out,
    output logic                 transfer_sync_oe_out,
    output logic                 transfer_sync_seen_out,
    // read ports
    input  wire logic [1:0]      read_port_clock_in,
    input  wire fmp_strobe_s     rd_strobe_in [RD_PORTS],
    input  wire logic [59:0]     rd_word_in [RD_PORTS],
    output fmp_addr_s            rd_addr_out [RD_PORTS],
    output logic [RD_PORTS-1:0]  rd_bit_out,
    output logic [RD_PORTS-1:0]  rd_active_out
);

    if (RD_PORTS < 1 || RD_PORTS > 2) begin : g_bad_ports
        $error("fmp_field_ctrl: RD_PORTS must be 1 or 2");
    end

    // write side state
    fmp_addr_s   wptr_r;
    logic [5:0]  wbit_r;
    logic [59:0] wword_r;
    logic        wok_r;
    logic        wrun_r;
    logic        wlr_pend_r;
    logic [8:0]  winc_r;

    // decoded write events
    logic        wtick;
    logic        wrec;
    logic        wrestart;
    logic        winc_ok;
    logic [8:0]  wn_eff;
    logic        wbit_ok;
    logic        wblk_end;
    logic        wmaster;
    logic        wfire;

    always_comb begin
        wtick    = write_port_clock_in;
        wrec     = recursive_select_in;
        wrestart = wrec ? wr_strobe_in.line_restart
                        : wr_strobe_in.block_restart;
        // increment coincident with line clear does not count
        winc_ok  = wr_strobe_in.line_inc && !wr_strobe_in.line_restart;
        wn_eff   = winc_ok ? fmp_inc_sat(winc_r) : winc_r;
        wbit_ok  = !wr_gate_n_in;
        wblk_end = wrun_r && !wrestart && wbit_r == LAST_BIT;
        wfire    = wtick && wblk_end;
        // preset low ignores the role pin and forces sync master
        wmaster  = !preset_select_in || !sync_role_select_in;
    end

    // write line and block pointer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wptr_r <= '0;
            wrun_r <= 1'b0;
        end else if (wtick) begin
            if (wrestart) begin
                wrun_r <= 1'b1;
                if (wrec) begin
                    wptr_r.line  <= LINE_RST;
                    wptr_r.block <= BLOCK_RST;
                end else begin
                    wptr_r.block <= preset_select_in ?
                        wr_preset_block_in : BLOCK_RST;
                    if (wr_strobe_in.line_restart || wlr_pend_r) begin
                        wptr_r.line <= fmp_line_add(LINE_RST, wn_eff);
                    end else begin
                        wptr_r.line <= fmp_line_add(wptr_r.line, wn_eff);
                    end
                end
            end else if (wblk_end) begin
                if (wrec) begin
                    wptr_r.block <= wptr_r.block + 4'h1;
                    if (wptr_r.block == LAST_BLOCK) begin
                        wptr_r.line <= (wptr_r.line == LAST_LINE) ?
                            LINE_RST : wptr_r.line + 9'h001;
                    end
                end else begin
                    if (wlr_pend_r) begin
                        wptr_r.line <= fmp_line_add(LINE_RST, winc_r);
                    end
                    if (wptr_r.block == LAST_BLOCK && !wlr_pend_r) begin
                        wrun_r <= 1'b0;
                    end else begin
                        wptr_r.block <= wptr_r.block + 4'h1;
                    end
                end
            end
        end
    end

    // pending line reset and increment count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wlr_pend_r <= 1'b0;
            winc_r     <= 9'h000;
        end else if (wtick) begin
            if (wrestart || (wblk_end && wlr_pend_r)) begin
                // increments after the block clear start afresh
                wlr_pend_r <= 1'b0;
                winc_r     <= 9'h000;
            end else if (!wrec && wr_strobe_in.line_restart) begin
                wlr_pend_r <= 1'b1;
                winc_r     <= 9'h000;
            end else if (!wrec && winc_ok) begin
                winc_r <= fmp_inc_sat(winc_r);
            end
        end
    end

    // bit position within the block
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wbit_r <= BIT_RST;
        end else if (wtick) begin
            if (wrestart) begin
                wbit_r <= 6'h01;
            end else if (wrun_r) begin
                wbit_r <= (wbit_r == LAST_BIT) ? BIT_RST : wbit_r + 6'h01;
            end
        end
    end

    // block assembly; a restart drops the partial block
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wword_r <= 60'h000000000000000;
            wok_r   <= 1'b0;
        end else if (wtick) begin
            if (wrestart) begin
                // data bit clocked with the strobe becomes bit 0
                wword_r    <= 60'h000000000000000;
                wword_r[0] <= wr_data_in;
                wok_r      <= wbit_ok;
            end else if (wrun_r) begin
                wword_r[wbit_r] <= wr_data_in;
                if (wbit_r == LAST_BIT) begin
                    wok_r <= 1'b1;
                end else if (!wbit_ok) begin
                    wok_r <= 1'b0;
                end
            end
        end
    end

    // committed block to the array
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_commit_out <= 1'b0;
            wr_addr_out   <= '0;
            wr_word_out   <= 60'h000000000000000;
        end else begin
            // only whole, ungated blocks reach the array
            wr_commit_out <= wfire && wok_r && wbit_ok;
            if (wfire && wok_r && wbit_ok) begin
                wr_addr_out           <= wptr_r;
                wr_word_out           <= wword_r;
                wr_word_out[LAST_BIT] <= wr_data_in;
            end
        end
    end

    // transfer sync between paired chips
    fmp_tsync u_tsync (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .tick_in     (wtick),
        .master_in   (wmaster),
        .fire_in     (wblk_end),
        .sync_in     (transfer_sync_in),
        .sync_out    (transfer_sync_out),
        .sync_oe_out (transfer_sync_oe_out),
        .seen_out    (transfer_sync_seen_out)
    );

    // read ports, each on its own port clock
    genvar gi;
    generate
        for (gi = 0; gi < RD_PORTS; gi++) begin : g_rd
            fmp_rd_port u_rd (
                .clk_in       (clk_in),
                .rst_in       (rst_in),
                .tick_in      (read_port_clock_in[gi]),
                .strobe_in    (rd_strobe_in[gi]),
                .recursive_in (recursive_select_in),
                .word_in      (rd_word_in[gi]),
                .addr_out     (rd_addr_out[gi]),
                .bit_out      (rd_bit_out[gi]),
                .active_out   (rd_active_out[gi])
            );
        end
    endgenerate

endmodule // fmp_field_ctrl

// ===== sim/fmp_array.sv
// array model behind the pointer control
`timescale 1ns/1ps
module fmp_array
    import fmp_pkg::*;
(
    // clock
    input  wire logic        clk_in,
    // write side
    input  wire logic        commit_in,
    input  wire fmp_addr_s   wr_addr_in,
    input  wire logic [59:0] wr_word_in,
    // read side
    input  wire fmp_addr_s   rd_addr_in [2],
    output logic [59:0]      rd_word_out [2]
);
    logic [59:0] mem [8192];

    // unwritten places hold a pattern unlike any written word
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = ~60'(i);
        end
    end

    // plain always: the array is also filled by the initial block
    always @(posedge clk_in) begin
        if (commit_in) begin
            mem[wr_addr_in] <= wr_word_in;
        end
    end

    assign rd_word_out[0] = mem[rd_addr_in[0]];
    assign rd_word_out[1] = mem[rd_addr_in[1]];
endmodule // fmp_array

// ===== sim/fmp_chk.sv
// assertions on the pointer control ports
`timescale 1ns/1ps
module fmp_chk
    import fmp_pkg::*;
#(
    parameter int RD_PORTS = 2
) (
    // clock and reset
    input wire logic                clk_in,
    input wire logic                rst_in,
    // modes and write port
    input wire logic                recursive_select_in,
    input wire logic                preset_select_in,
    input wire logic                sync_role_select_in,
    input wire logic                write_port_clock_in,
    input wire logic                wr_gate_n_in,
    input wire logic                wr_commit_out,
    input wire fmp_addr_s           wr_addr_out,
    input wire logic [59:0]         wr_word_out,
    input wire logic                transfer_sync_out,
    input wire logic                transfer_sync_oe_out,
    // read ports
    input wire logic [1:0]          read_port_clock_in,
    input wire logic [RD_PORTS-1:0] rd_bit_out,
    input wire logic [RD_PORTS-1:0] rd_active_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // sync role held steady over three edges
    sequence s_master;
        !preset_select_in [*3];
    endsequence
    sequence s_slave;
        (preset_select_in && sync_role_select_in) [*3];
    endsequence

    a_commit_tick: assert property (
        wr_commit_out |-> $past(write_port_clock_in))
        else $error("commit without write tick");
    a_commit_single: assert property (
        wr_commit_out |=> !wr_commit_out [*8])
        else $error("commits closer than a block");
    a_gate_drop: assert property (
        recursive_select_in && write_port_clock_in && wr_gate_n_in
        |=> !wr_commit_out)
        else $error("gated block committed");
    a_addr_stand: assert property (
        !wr_commit_out |-> $stable(wr_addr_out) && $stable(wr_word_out))
        else $error("commit address moved without commit");
    a_oe_master: assert property (s_master |-> transfer_sync_oe_out)
        else $error("sync pin not driven with preset low");
    a_oe_slave: assert property (s_slave |-> !transfer_sync_oe_out)
        else $error("slave drives sync pin");
    a_sync_drv: assert property (
        transfer_sync_out |-> transfer_sync_oe_out)
        else $error("sync pulse while pin released");
    a_rd_hold: assert property (
        !read_port_clock_in[0] |=> $stable(rd_bit_out[0]))
        else $error("read bit changed without tick");
    a_rd_start: assert property (
        $rose(rd_active_out[0]) |-> $past(read_port_clock_in[0]))
        else $error("read port started without tick");
endmodule // fmp_chk

bind fmp_field_ctrl fmp_chk #(
    .RD_PORTS(RD_PORTS)
) u_chk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .recursive_select_in(recursive_select_in),
    .preset_select_in(preset_select_in),
    .sync_role_select_in(sync_role_select_in),
    .write_port_clock_in(write_port_clock_in),
    .wr_gate_n_in(wr_gate_n_in),
    .wr_commit_out(wr_commit_out),
    .wr_addr_out(wr_addr_out),
    .wr_word_out(wr_word_out),
    .transfer_sync_out(transfer_sync_out),
    .transfer_sync_oe_out(transfer_sync_oe_out),
    .read_port_clock_in(read_port_clock_in),
    .rd_bit_out(rd_bit_out),
    .rd_active_out(rd_active_out)
);

// ===== sim/tb_top.sv
// self-checking bench for the field memory pointer control
`timescale 1ns/1ps
module tb_top
    import fmp_pkg::*;
;
    localparam logic [2:0] LR = 3'h4, BR = 3'h2, INC = 3'h1, NONE = 3'h0;

    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        rec_sel = 1'b1, pre_sel = 1'b0, role_sel = 1'b0;
    logic        wck = 1'b0, wgate_n = 1'b0, wdat = 1'b0;
    logic        sync_drv = 1'b0;
    logic [3:0]  wpre = 4'h0;
    logic [1:0]  rck = 2'h0;
    fmp_strobe_s wstb = '0;
    fmp_strobe_s rstb [2] = '{default: '0};
    logic        commit, sync_out, sync_oe, sync_seen;
    fmp_addr_s   waddr;
    fmp_addr_s   raddr [2];
    logic [59:0] wword;
    logic [59:0] rword [2];
    logic [1:0]  rbit, ract;
    wire         sync_pin = sync_oe ? sync_out : sync_drv;
    int          num_errors = 0, checked = 0, cyc = 0;
    bit          gap = 1'b0;
    fmp_addr_s   qa [$];
    logic [59:0] qw [$];

    fmp_field_ctrl #(
        .RD_PORTS(2)
    ) dut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .recursive_select_in(rec_sel),
        .preset_select_in(pre_sel),
        .sync_role_select_in(role_sel),
        .write_port_clock_in(wck),
        .wr_strobe_in(wstb),
        .wr_gate_n_in(wgate_n),
        .wr_preset_block_in(wpre),
        .wr_data_in(wdat),
        .wr_commit_out(commit),
        .wr_addr_out(waddr),
        .wr_word_out(wword),
        .transfer_sync_in(sync_pin),
        .transfer_sync_out(sync_out),
        .transfer_sync_oe_out(sync_oe),
        .transfer_sync_seen_out(sync_seen),
        .read_port_clock_in(rck),
        .rd_strobe_in(rstb),
        .rd_word_in(rword),
        .rd_addr_out(raddr),
        .rd_bit_out(rbit),
        .rd_active_out(ract)
    );

    fmp_array u_arr (
        .clk_in(clk_in),
        .commit_in(commit),
        .wr_addr_in(waddr),
        .wr_word_in(wword),
        .rd_addr_in(raddr),
        .rd_word_out(rword)
    );

    initial forever #5 clk_in = ~clk_in;

    // commit log and hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (commit === 1'b1) begin
            qa.push_back(waddr);
            qw.push_back(wword);
        end
        if (cyc == 40000) begin
            num_errors++;
            $display("[FAIL] run time expected end seen running");
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [63:0] e,
                       input logic [63:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic logic [59:0] pat(input int k);
        return {12{k[4:0]}} ^ 60'h3C5A96F0E1DB247;
    endfunction

    task automatic cq(input int i, input int l, input int b, input int k);
        chk("commit addr", {l[8:0], b[3:0]}, qa[i]);
        chk("commit word", pat(k), qw[i]);
    endtask

    task automatic done(input string n);
        $display("test %s finished, %0d mismatches", n, num_errors);
    endtask

    // one write port tick, optionally followed by a tick-free cycle
    task automatic wb(input logic [2:0] s, input logic g, input logic d);
        @(posedge clk_in);
        wstb <= fmp_strobe_s'(s);
        wgate_n <= g;
        wdat <= d;
        wck <= 1'b1;
        if (gap) begin
            @(posedge clk_in);
            wck <= 1'b0;
        end
    endtask

    task automatic wblk(input logic [2:0] s, input int k, input int bad,
                        input int len);
        logic [59:0] w;
        w = pat(k);
        for (int i = 0; i < len; i++) begin
            wb(i == 0 ? s : NONE, i == bad, w[i]);
        end
    endtask

    task automatic idle(input bit clr);
        @(posedge clk_in);
        wck <= 1'b0;
        rck <= 2'h0;
        repeat (4) @(posedge clk_in);
        if (clr) begin
            qa.delete();
            qw.delete();
        end
    endtask

    task automatic t_rec_wrap();
        rec_sel <= 1'b1;
        idle(1'b1);
        wblk(LR, 0, -1, 60);
        for (int k = 1; k < 17; k++) begin
            wblk(NONE, k, -1, 60);
        end
        idle(1'b0);
        chk("commits", 17, qa.size());
        cq(0, 0, 0, 0);
        cq(15, 0, 15, 15);
        cq(16, 1, 0, 16);
        done("rec_wrap");
    endtask

    task automatic t_gate();
        gap = 1'b1;
        idle(1'b1);
        wblk(LR, 1, -1, 30);
        wblk(LR, 2, 7, 60);
        wblk(NONE, 3, -1, 60);
        idle(1'b0);
        gap = 1'b0;
        chk("commits", 1, qa.size());
        cq(0, 0, 1, 3);
        done("gate");
    endtask

    task automatic t_nonrec();
        logic [59:0] w;
        w = pat(21);
        rec_sel <= 1'b0;
        idle(1'b1);
        wblk(LR | BR, 0, -1, 60);
        for (int k = 1; k < 17; k++) begin
            wblk(NONE, k, -1, 60);
        end
        wb(INC, 1'b0, 1'b0);
        wb(INC, 1'b0, 1'b0);
        wblk(BR, 20, -1, 60);
        for (int i = 0; i < 60; i++) begin
            wb(i == 10 ? LR | INC : (i % 10 == 0 && i > 10) ? INC : NONE,
               1'b0, w[i]);
        end
        wblk(NONE, 22, -1, 60);
        pre_sel <= 1'b1;
        wpre <= 4'h9;
        wblk(BR, 23, -1, 60);
        idle(1'b0);
        pre_sel <= 1'b0;
        chk("commits", 20, qa.size());
        cq(19, 4, 9, 23);
        cq(15, 0, 15, 15);
        cq(16, 2, 0, 20);
        cq(17, 2, 1, 21);
        cq(18, 4, 2, 22);
        done("nonrec");
    endtask

    task automatic t_read();
        logic [1:0]  held;
        logic [1:0]  e;
        logic [59:0] w0, w1;
        w0 = pat(5);
        w1 = pat(6);
        rec_sel <= 1'b1;
        idle(1'b1);
        rck <= 2'h3;
        fork
            begin
                wblk(LR, 5, -1, 60);
                wblk(NONE, 6, -1, 60);
                wblk(NONE, 7, -1, 60);
            end
            begin
                repeat (130) @(posedge clk_in);
                rstb[0] <= fmp_strobe_s'(LR);
                rstb[1] <= fmp_strobe_s'(LR);
                @(posedge clk_in);
                rstb[0] <= '0;
                rstb[1] <= '0;
                @(posedge clk_in);
                #1 held = rbit;
                for (int j = 2; j < 184; j++) begin
                    @(posedge clk_in);
                    #1;
                    e = j < 64 ? held :
                        j < 124 ? {2{w0[j-64]}} : {2{w1[j-124]}};
                    chk("read bits", e, rbit);
                end
            end
        join
        done("read");
    endtask

    task automatic t_sync();
        int n;
        n = 0;
        @(posedge clk_in);
        role_sel <= 1'b1;
        repeat (5) @(posedge clk_in);
        for (int i = 0; i < 120; i++) begin
            @(posedge clk_in);
            n += int'(sync_out === 1'b1);
        end
        #1;
        chk("sync count", 10, n);
        chk("master oe", 1, sync_oe);
        @(posedge clk_in);
        pre_sel <= 1'b1;
        sync_drv <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        chk("slave oe", 0, sync_oe);
        chk("seen", 1, sync_seen);
        @(posedge clk_in);
        role_sel <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        chk("master oe", 1, sync_oe);
        done("sync");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (20000) @(posedge clk_in);
        t_rec_wrap();
        t_gate();
        t_nonrec();
        t_read();
        t_sync();
        tally_and_finish();
    end
endmodule // tb_top
